// ### pkg/pae_pkg.sv
// Package: register map, field layout, reset values and alarm type codes
package pae_pkg;

  localparam int unsigned PV_W = 16;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_SP      = 8'h00;
  localparam logic [7:0] OFF_PV      = 8'h04;
  localparam logic [7:0] OFF_STATE   = 8'h08;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFF_ASSIGN  = 8'h14;
  localparam logic [7:0] OFF_CFG0    = 8'h20;
  localparam logic [7:0] OFF_THR0    = 8'h24;
  localparam logic [7:0] OFF_HYS0    = 8'h28;
  localparam logic [7:0] ALM_STRIDE  = 8'h10;

  // Per-alarm configuration fields
  localparam int unsigned CFG_TYPE_LSB = 0;
  localparam int unsigned CFG_POL_BIT  = 4;
  localparam int unsigned CFG_DP_LSB   = 8;

  // Reset values
  localparam logic [3:0]      RST_TYPE = 4'h2;
  localparam logic [PV_W-1:0] RST_THR  = 16'h0000;
  localparam logic [PV_W-1:0] RST_HYS  = 16'h0002;
  localparam logic [PV_W-1:0] RST_SP   = 16'h0000;

  typedef enum logic [3:0] {
    PAE_T_NONE   = 4'b0000,
    PAE_T_UPLO   = 4'b0001,
    PAE_T_UP     = 4'b0010,
    PAE_T_LO     = 4'b0011,
    PAE_T_RANGE  = 4'b0100,
    PAE_T_UPLO_S = 4'b0101,
    PAE_T_UP_S   = 4'b0110,
    PAE_T_LO_S   = 4'b0111,
    PAE_T_ABS_UP = 4'b1000,
    PAE_T_ABS_LO = 4'b1001,
    PAE_T_AUP_S  = 4'b1010,
    PAE_T_ALO_S  = 4'b1011
  } pae_alarm_type;

endpackage : pae_pkg

// ### rtl/pae_alarm_unit.sv
// One alarm channel: comparison, hysteresis and standby sequence
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_unit (
  input  wire logic                      core_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [3:0]                type_i,
  input  wire logic signed [pae_pkg::PV_W-1:0] thr_i,
  input  wire logic [pae_pkg::PV_W-1:0]  hys_i,
  input  wire logic signed [pae_pkg::PV_W-1:0] sp_i,
  input  wire logic signed [pae_pkg::PV_W-1:0] pv_i,
  output logic                           alarm_o
);
  import pae_pkg::*;

  localparam int unsigned W = PV_W + 2;

  logic signed [W-1:0] pv_x;
  logic signed [W-1:0] sp_x;
  logic signed [W-1:0] thr_x;
  logic signed [W-1:0] hys_x;
  logic signed [W-1:0] hi_lim;
  logic signed [W-1:0] lo_lim;
  logic                is_abs;
  logic                standby;
  logic                in_on;
  logic                in_off;
  logic                armed;
  logic                next_alarm;

  assign pv_x   = W'(pv_i);
  assign sp_x   = W'(sp_i);
  assign thr_x  = W'(thr_i);
  assign hys_x  = W'({1'b0, hys_i});
  assign is_abs = type_i[3];
  assign standby = (type_i == PAE_T_UPLO_S) || (type_i == PAE_T_UP_S) ||
                   (type_i == PAE_T_LO_S) || (type_i == PAE_T_AUP_S) ||
                   (type_i == PAE_T_ALO_S);
  // Trip levels: deviation from set point, or absolute level
  assign hi_lim = is_abs ? thr_x : sp_x + thr_x;
  assign lo_lim = is_abs ? thr_x : sp_x - thr_x;

  // in_on: enter alarm; in_off: still in alarm with hysteresis margin
  always_comb begin
    in_on  = 1'b0;
    in_off = 1'b0;
    case (type_i)
      PAE_T_UPLO: begin
        in_on  = thr_i[PV_W-1] || pv_x > hi_lim || pv_x < lo_lim;
        in_off = thr_i[PV_W-1] || pv_x > hi_lim - hys_x ||
                 pv_x < lo_lim + hys_x;
      end
      PAE_T_UPLO_S: begin
        in_on  = !thr_i[PV_W-1] && (pv_x > hi_lim || pv_x < lo_lim);
        in_off = !thr_i[PV_W-1] && (pv_x > hi_lim - hys_x ||
                 pv_x < lo_lim + hys_x);
      end
      PAE_T_RANGE: begin
        in_on  = !thr_i[PV_W-1] && pv_x <= hi_lim && pv_x >= lo_lim;
        in_off = !thr_i[PV_W-1] && pv_x <= hi_lim + hys_x &&
                 pv_x >= lo_lim - hys_x;
      end
      PAE_T_UP, PAE_T_UP_S, PAE_T_ABS_UP, PAE_T_AUP_S: begin
        in_on  = pv_x > hi_lim;
        in_off = pv_x > hi_lim - hys_x;
      end
      PAE_T_LO, PAE_T_LO_S: begin
        in_on  = pv_x < lo_lim;
        in_off = pv_x < lo_lim + hys_x;
      end
      PAE_T_ABS_LO, PAE_T_ALO_S: begin
        in_on  = pv_x < thr_x;
        in_off = pv_x < thr_x + hys_x;
      end
      default: begin
        in_on  = 1'b0;
        in_off = 1'b0;
      end
    endcase
  end

  // Standby: arm once the value is outside the alarm range
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      armed <= 1'b0;
    end else if (standby && !in_on) begin
      armed <= 1'b1;
    end
  end

  assign next_alarm = (alarm_o ? in_off : in_on) && (armed || !standby);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      alarm_o <= 1'b0;
    end else begin
      alarm_o <= next_alarm;
    end
  end

endmodule : pae_alarm_unit
`default_nettype wire

// ### rtl/pae_top.sv
// Process alarm evaluator: Wishbone registers, three alarm channels, outputs
//
// Overview of operation
// - Three independent alarms exist, and each reaches an output only when assigned to it; here each also drives its LED whatever the assignment.
// - Each alarm state comes from its type, signed threshold and hysteresis applied to the process value.
// - Each alarm has its own contact polarity bit, independent of others and of type.
// - Type codes 1 to 11; 1-7 compare against set point plus or minus threshold, 8-11 against absolute threshold.
// - Type 1 with a negative threshold is always asserted.
// - Types 4 and 5 with a negative threshold are never asserted.
// - Standby types 5, 6, 7, 10, 11 stay off until the value has left the range once and re-entered.
// - Each alarm keeps its own type code, resetting to 2.
// - Each alarm keeps its own signed threshold, resetting to 0, whose sign shapes the comparison.
// - Each alarm keeps its own hysteresis width, resetting to 0.02 percent of full scale.
// - Normally-open output equals the alarm, normally-closed inverts it; the LED shows the alarm.
// - The threshold decimal point follows the input scaling or sensor resolution setting.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pae_top (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [pae_pkg::PV_W-1:0] process_value_i,
  input  wire logic [3:0]  input_dp_i,
  output logic [3:0]       contact_o,
  output logic [2:0]       alarm_led_o,
  output logic             irq_o
);
  import pae_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [PV_W-1:0] set_point;
  logic [3:0]      alm_type [3];
  logic            alm_pol  [3];
  logic [PV_W-1:0] alm_thr  [3];
  logic [PV_W-1:0] alm_hys  [3];
  logic [1:0]      assign_sel [4];
  logic [2:0]      irq_status;
  logic [2:0]      irq_mask;
  logic [2:0]      alarm;
  logic [2:0]      alarm_d;
  logic            req;
  logic            wr;
  logic [2:0]      idx;
  logic [7:0]      rel;
  logic [31:0]     next_rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;

  // Channel index and offset within channel block
  always_comb begin
    idx = 3'd3;
    rel = 8'h00;
    if (wb_adr_i >= OFF_CFG0 && wb_adr_i < OFF_CFG0 + 3 * ALM_STRIDE) begin
      idx = 3'((wb_adr_i - OFF_CFG0) / ALM_STRIDE);
      rel = 8'(((wb_adr_i - OFF_CFG0) % ALM_STRIDE) + OFF_CFG0);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      set_point <= RST_SP;
      irq_mask  <= 3'h0;
      assign_sel[0] <= 2'd0;
      assign_sel[1] <= 2'd1;
      assign_sel[2] <= 2'd2;
      assign_sel[3] <= 2'd3;
      for (int i = 0; i < 3; i++) begin
        alm_type[i] <= RST_TYPE;
        alm_pol[i]  <= 1'b0;
        alm_thr[i]  <= RST_THR;
        alm_hys[i]  <= RST_HYS;
      end
    end else if (wr && wb_sel_i == 4'hF) begin
      if (wb_adr_i == OFF_SP) begin
        set_point <= wb_dat_i[PV_W-1:0];
      end else if (wb_adr_i == OFF_IRQ_MSK) begin
        irq_mask <= wb_dat_i[2:0];
      end else if (wb_adr_i == OFF_ASSIGN) begin
        for (int k = 0; k < 4; k++) begin
          assign_sel[k] <= wb_dat_i[2*k +: 2];
        end
      end else if (idx != 3'd3 && rel == OFF_CFG0) begin
        alm_type[idx[1:0]] <= wb_dat_i[CFG_TYPE_LSB +: 4];
        alm_pol[idx[1:0]]  <= wb_dat_i[CFG_POL_BIT];
      end else if (idx != 3'd3 && rel == OFF_THR0) begin
        alm_thr[idx[1:0]] <= wb_dat_i[PV_W-1:0];
      end else if (idx != 3'd3 && rel == OFF_HYS0) begin
        alm_hys[idx[1:0]] <= wb_dat_i[PV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == OFF_SP) begin
      next_rdata = 32'(set_point);
    end else if (wb_adr_i == OFF_PV) begin
      next_rdata = 32'(process_value_i);
    end else if (wb_adr_i == OFF_STATE) begin
      next_rdata = {25'h0, contact_o, alarm};
    end else if (wb_adr_i == OFF_IRQ_ST) begin
      next_rdata = 32'(irq_status);
    end else if (wb_adr_i == OFF_IRQ_MSK) begin
      next_rdata = 32'(irq_mask);
    end else if (wb_adr_i == OFF_ASSIGN) begin
      next_rdata = {24'h0, assign_sel[3], assign_sel[2], assign_sel[1], assign_sel[0]};
    end else if (idx != 3'd3 && rel == OFF_CFG0) begin
      // Threshold decimal point mirrors the input scaling setting
      next_rdata = {20'h0, input_dp_i, 3'h0, alm_pol[idx[1:0]],
                    alm_type[idx[1:0]]};
    end else if (idx != 3'd3 && rel == OFF_THR0) begin
      next_rdata = 32'(alm_thr[idx[1:0]]);
    end else if (idx != 3'd3 && rel == OFF_HYS0) begin
      next_rdata = 32'(alm_hys[idx[1:0]]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Alarm channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_alm
      pae_alarm_unit u_alarm (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .type_i     (alm_type[g]),
        .thr_i      (alm_thr[g]),
        .hys_i      (alm_hys[g]),
        .sp_i       (set_point),
        .pv_i       (process_value_i),
        .alarm_o    (alarm[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      contact_o   <= 4'h0;
      alarm_led_o <= 3'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (assign_sel[k] == 2'd3) begin
          contact_o[k] <= 1'b0;
        end else begin
          contact_o[k] <= alarm[assign_sel[k]] ^ alm_pol[assign_sel[k]];
        end
      end
      alarm_led_o <= alarm;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      alarm_d    <= 3'h0;
      irq_status <= 3'h0;
    end else begin
      alarm_d <= alarm;
      if (wr && wb_sel_i[0] && wb_adr_i == OFF_IRQ_ST) begin
        irq_status <= (irq_status & ~wb_dat_i[2:0]) | (alarm & ~alarm_d);
      end else begin
        irq_status <= irq_status | (alarm & ~alarm_d);
      end
    end
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule : pae_top
`default_nettype wire

// ### tb/pae_relay_model.sv
// Behavioural model of the alarm relay contacts and indicator lamps
`timescale 1ns/1ps
`default_nettype none
module pae_relay_model (
  input  wire logic [3:0] contact_i,
  input  wire logic [2:0] led_i,
  input  wire logic       core_clk_i,
  output logic [3:0]      closed_o,
  output logic [2:0]      lit_o
);
  // Relays and lamps follow their drives one clock late
  always_ff @(posedge core_clk_i) begin
    closed_o <= contact_i;
    lit_o    <= led_i;
  end
endmodule : pae_relay_model
`default_nettype wire

// ### tb/pae_checker.sv
// Port-level assertions for the process alarm evaluator
`timescale 1ns/1ps
`default_nettype none
module pae_checker
  import pae_pkg::*;
(
  input wire logic                     core_clk_i,
  input wire logic                     sys_rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic [pae_pkg::PV_W-1:0] process_value_i,
  input wire logic [3:0]               input_dp_i,
  input wire logic [3:0]               contact_o,
  input wire logic [2:0]               alarm_led_o,
  input wire logic                     irq_o
);
  logic [2:0] pol;
  logic [7:0] asg;
  logic [1:0] quiet;
  logic [3:0] exp_ct;
  logic       wr;
  // Write lands on the edge that takes the request, as in the design
  assign wr = !wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i && wb_sel_i == 4'hF;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of writes that shape the contacts
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pol   <= 3'h0;
      asg   <= 8'hE4;
      quiet <= 2'h0;
    end else begin
      quiet <= wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      if (wr && wb_adr_i == OFF_ASSIGN) asg <= wb_dat_i[7:0];
      for (int a = 0; a < 3; a++) begin
        if (wr && wb_adr_i == OFF_CFG0 + ALM_STRIDE * 8'(a)) pol[a] <= wb_dat_i[CFG_POL_BIT];
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      exp_ct[k] = asg[2*k+:2] != 2'h3 && (alarm_led_o[asg[2*k+:2]] ^ pol[asg[2*k+:2]]);
    end
  end
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  rdata_hold_a: assert property (!(wb_cyc_i && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved without read");
  reset_quiet_a: assert property ($fell(sys_rst_i) |-> !irq_o && contact_o == 4'h0 &&
    alarm_led_o == 3'h0) else $error("outputs not idle after reset");
  contact_map_a: assert property (quiet == 2'h3 |-> contact_o == exp_ct)
    else $error("contact does not follow alarm");
  irq_cause_a: assert property ($rose(irq_o) && quiet != 2'h0 |->
    (alarm_led_o & ~$past(alarm_led_o)) != 3'h0) else $error("irq without alarm rise");
  irq_sticky_a: assert property ($fell(irq_o) |-> quiet == 2'h0)
    else $error("irq dropped without write");
  cover property (wr && wb_adr_i == OFF_ASSIGN);
  cover property ($rose(irq_o));
  cover property ($fell(alarm_led_o[0]));
endmodule : pae_checker
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the process alarm evaluator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pae_pkg::*;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic              core_clk_i = 1'b0;
  logic              sys_rst_i  = 1'b1;
  logic              cyc        = 1'b0;
  logic              stb        = 1'b0;
  logic              we         = 1'b0;
  logic [7:0]        adr        = 8'h00;
  logic [31:0]       dat_w      = ZERO;
  logic [PV_W-1:0]   pv         = 16'h0000;
  logic [3:0]        dp         = 4'h3;
  logic [31:0]       rd;
  wire logic [31:0]  dat_r;
  wire logic         ack;
  wire logic         irq;
  wire logic [3:0]   contact;
  wire logic [3:0]   closed;
  wire logic [2:0]   led;
  wire logic [2:0]   lit;
  int                mismatches = 0;
  int                num_checks = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  pae_top i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .process_value_i(pv), .input_dp_i(dp),
    .contact_o(contact), .alarm_led_o(led), .irq_o(irq));
  pae_relay_model i_relay (.core_clk_i(core_clk_i), .contact_i(contact), .led_i(led),
    .closed_o(closed), .lit_o(lit));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wt
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) chk("ack", 32'h0000_0001, ZERO);
  endtask : wb
  task automatic spv(input logic [15:0] v);
    @(posedge core_clk_i);
    pv <= v;
    wt(4);
  endtask : spv
  task automatic rst;
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
  endtask : rst
  task automatic tcfg(input logic [11:0] ty, input logic [47:0] th);
    rst;
    for (int a = 0; a < 3; a++) begin
      wb(1'b1, OFF_CFG0 + ALM_STRIDE * 8'(a), 32'(ty[4*a+:4]));
      wb(1'b1, OFF_THR0 + ALM_STRIDE * 8'(a), 32'(th[16*a+:16]));
    end
  endtask : tcfg
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    mismatches++;
    end_sim;
  end
  initial begin
    rst;
    for (int a = 0; a < 3; a++) begin
      wb(1'b0, OFF_CFG0 + ALM_STRIDE * 8'(a), ZERO);
      chk("cfg", 32'h0000_0302, rd);
      wb(1'b0, OFF_THR0 + ALM_STRIDE * 8'(a), ZERO);
      chk("thr", ZERO, rd);
      wb(1'b0, OFF_HYS0 + ALM_STRIDE * 8'(a), ZERO);
      chk("hys", 32'h0000_0002, rd);
    end
    wb(1'b0, 8'hFC, ZERO);
    chk("unmapped", ZERO, rd);
    @(posedge core_clk_i);
    dp <= 4'h5;
    wb(1'b0, OFF_CFG0 + ALM_STRIDE * 8'd2, ZERO);
    chk("cfg dp", 32'h0000_0502, rd);
    $display("test reset done");
    spv(16'h0064);
    chk("lit", 32'h0000_0007, lit);
    chk("closed", 32'h0000_0007, closed);
    spv(16'h0000);
    chk("hold", 32'h0000_0007, lit);
    spv(16'hFFFB);
    chk("release", ZERO, lit);
    wb(1'b1, OFF_SP, 32'h0000_00C8);
    spv(16'h0096);
    chk("sp", ZERO, lit);
    $display("test deviation done");
    rst;
    spv(16'h0064);
    wb(1'b1, OFF_ASSIGN, 32'h0000_0024);
    wt(4);
    chk("assign", 32'h0000_000F, closed);
    wb(1'b1, OFF_CFG0 + ALM_STRIDE, 32'h0000_0012);
    wt(4);
    chk("pol on", 32'h0000_000D, closed);
    chk("led", 32'h0000_0007, lit);
    spv(16'hFFFB);
    chk("pol off", 32'h0000_0002, closed);
    wb(1'b0, OFF_STATE, ZERO);
    chk("state", 32'h0000_0010, rd);
    wb(1'b0, OFF_PV, ZERO);
    chk("pv", 32'h0000_FFFB, rd);
    $display("test polarity done");
    chk("irq masked", ZERO, irq);
    wb(1'b0, OFF_IRQ_ST, ZERO);
    chk("status", 32'h0000_0007, rd);
    wb(1'b1, OFF_IRQ_MSK, 32'h0000_0001);
    wt(2);
    chk("irq on", 32'h0000_0001, irq);
    wb(1'b1, OFF_IRQ_ST, 32'h0000_0001);
    wt(2);
    chk("irq clear", ZERO, irq);
    spv(16'h0064);
    chk("irq again", 32'h0000_0001, irq);
    $display("test irq done");
    tcfg(12'h541, 48'hFFFF_FFFF_FFFF);
    spv(16'h03E8);
    chk("neg high", 32'h0000_0001, lit);
    spv(16'hFC18);
    chk("neg low", 32'h0000_0001, lit);
    tcfg(12'h398, 48'h0000_0032_0032);
    wb(1'b1, OFF_SP, 32'h0000_03E8);
    spv(16'h003C);
    chk("abs up", 32'h0000_0005, lit);
    spv(16'h0028);
    chk("abs low", 32'h0000_0006, lit);
    $display("test types done");
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i);
      pv <= 16'h0064;
      rst;
      wb(1'b1, OFF_CFG0, 32'h0000_000A);
      wt(4);
      chk("standby", ZERO, lit[0]);
      spv(16'hFF9C);
      spv(16'h0064);
      chk("re-enter", 32'h0000_0001, lit[0]);
    end
    $display("test standby done");
    end_sim;
  end
endmodule : tb_top
bind pae_top pae_checker i_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .process_value_i(process_value_i), .input_dp_i(input_dp_i), .contact_o(contact_o),
  .alarm_led_o(alarm_led_o), .irq_o(irq_o));
`default_nettype wire
